// ==== rtl/fdf_fir_decim.sv ====
`include "fdf_consts.svh"
`default_nettype none
// Function
// - The last N accepted samples are held in a delay line of N taps.
// - Each output is the sum of the N tap-by-coefficient products.
// - Only one filtered value in every M is passed; the rest are dropped.
// - A full multiply-accumulate pass runs only on every Mth input.
// - Exactly M new samples enter the delay line between passes.
// - Output m is the sum of h(k) times x(M*m+M-1-k) for k from 0 to N-1.
// - With M of 4 one output leaves per four inputs.
// - An input counter counts down from M, fires at zero, then reloads M.
// - A sum that overflows the output width saturates instead of wrapping.

// ***************************************************************
// Sample FIFO
// ***************************************************************
module fdf_fifo #(
  parameter int WIDTH = `FDF_DATA_W,
  parameter int DEPTH = `FDF_FIFO_DEPTH,
  parameter int AW = `FDF_FIFO_AW
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  assign wr_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign rd_valid_out = wp_q != rp_q;
  assign rd_data_out = mem_q[rp_q[AW-1:0]];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      wp_d = wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = rp_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage carries no reset; only the pointers define content
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= wr_data_in;
    end
  end
endmodule

// ***************************************************************
// Decimating FIR core
// ***************************************************************
module fdf_fir_decim (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire fdf_pkg::fdf_coef_wr_t coef_wr_in,
  input wire fdf_pkg::fdf_sample_t in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output fdf_pkg::fdf_sample_t out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic busy_out
);
  localparam int N = `FDF_TAPS;
  localparam int SW = `FDF_DATA_W;
  localparam int AWD = `FDF_ACC_W;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Last tap: both the clear walk and a pass end here
  function automatic logic is_last(input fdf_pkg::fdf_tap_idx_t i);
    return i == `FDF_TAP_IW'(N - 1);
  endfunction

  // N is not a power of two, so pointers wrap by compare, not overflow
  function automatic fdf_pkg::fdf_tap_idx_t idx_wrap(
    input fdf_pkg::fdf_tap_idx_t i);
    if (is_last(i)) begin
      return '0;
    end
    return i + 1'b1;
  endfunction

  function automatic fdf_pkg::fdf_sample_t sat(input fdf_pkg::fdf_acc_t a);
    fdf_pkg::fdf_acc_t hi, lo;
    hi = AWD'(signed'({1'b0, {(SW-1){1'b1}}}));
    lo = -hi - AWD'(1);
    if (a > hi) begin
      return {1'b0, {(SW-1){1'b1}}};
    end
    if (a < lo) begin
      return {1'b1, {(SW-1){1'b0}}};
    end
    return a[SW-1:0];
  endfunction

  // ***************************************************************
  // Input FIFO and storage
  // ***************************************************************
  fdf_pkg::fdf_sample_t fifo_data;
  logic fifo_valid, fifo_take;

  fdf_fifo #(.WIDTH(SW), .DEPTH(`FDF_FIFO_DEPTH), .AW(`FDF_FIFO_AW)) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(in_data_in),
    .wr_valid_in(in_valid_in),
    .wr_ready_out(in_ready_out),
    .rd_data_out(fifo_data),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_take)
  );

  // Coefficients stored reversed so oldest sample pairs with h(N-1)
  fdf_pkg::fdf_coef_t coef_q [N];
  fdf_pkg::fdf_sample_t line_q [N];

  fdf_pkg::fdf_state_t st_q, st_d;
  fdf_pkg::fdf_tap_idx_t wr_q, wr_d, rd_q, rd_d, k_q, k_d;
  logic [`FDF_CNT_W-1:0] cnt_q, cnt_d;
  fdf_pkg::fdf_acc_t acc_q, acc_d;
  fdf_pkg::fdf_sample_t out_q, out_d;
  logic ov_q, ov_d;
  logic clr_q, clr_d;
  logic [`FDF_CNT_W-1:0] cnt_dec;
  fdf_pkg::fdf_acc_t prod;
  logic pass_start, mac_on, emit_fire;
  logic line_we;
  fdf_pkg::fdf_sample_t line_wdata;

  // Taking a sample only while idle keeps exactly M between passes
  assign fifo_take = fifo_valid && (st_q == fdf_pkg::FDF_IDLE) && !clr_q;
  assign cnt_dec = cnt_q - 1'b1;
  // The Mth sample starts a pass; the other M-1 are stored and only move the counter
  assign pass_start = fifo_take && (cnt_dec == '0);
  assign mac_on = (st_q == fdf_pkg::FDF_MAC);
  assign emit_fire = (st_q == fdf_pkg::FDF_EMIT) && (!ov_q || out_ready_in);
  assign prod = AWD'(line_q[rd_q] * coef_q[k_q]);
  assign out_data_out = out_q;
  assign out_valid_out = ov_q;
  assign busy_out = (st_q != fdf_pkg::FDF_IDLE) || clr_q;

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    wr_d = wr_q;
    rd_d = rd_q;
    k_d = k_q;
    cnt_d = cnt_q;
    clr_d = clr_q;
    if (clr_q) begin
      // Line clearing walks all taps after reset
      wr_d = idx_wrap(wr_q);
      if (is_last(wr_q)) begin
        clr_d = 1'b0;
      end
    end else begin
      unique case (st_q)
        fdf_pkg::FDF_IDLE: begin
          if (fifo_take) begin
            wr_d = idx_wrap(wr_q);
            cnt_d = cnt_dec;
          end
          if (pass_start) begin
            cnt_d = `FDF_CNT_W'(`FDF_DECIM);
            rd_d = idx_wrap(wr_q); // Oldest sample after this write
            k_d = '0;
            st_d = fdf_pkg::FDF_MAC;
          end
        end
        fdf_pkg::FDF_MAC: begin
          // One tap per cycle: oldest sample first, newest last
          rd_d = idx_wrap(rd_q);
          k_d = k_q + 1'b1;
          if (is_last(k_q)) begin
            st_d = fdf_pkg::FDF_EMIT;
          end
        end
        fdf_pkg::FDF_EMIT: begin
          // Holds the pass until the sink has taken the previous one
          if (emit_fire) begin
            st_d = fdf_pkg::FDF_IDLE;
          end
        end
        default: begin
          // The spare state code falls back to idle instead of locking up
          st_d = fdf_pkg::FDF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_q <= fdf_pkg::FDF_IDLE;
      wr_q <= '0;
      rd_q <= '0;
      k_q <= '0;
      cnt_q <= `FDF_CNT_W'(`FDF_DECIM);
      clr_q <= 1'b1;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      k_q <= k_d;
      cnt_q <= cnt_d;
      clr_q <= clr_d;
    end
  end

  // ***************************************************************
  // Accumulator
  // ***************************************************************
  // 40 bits hold 300 full products without wrap; only the output saturates
  always_comb begin
    acc_d = acc_q;
    if (pass_start) begin
      acc_d = `FDF_ACC_RST;
    end else if (mac_on) begin
      acc_d = acc_q + prod;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_q <= `FDF_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ***************************************************************
  // Output register
  // ***************************************************************
  always_comb begin
    out_d = out_q;
    ov_d = ov_q;
    if (ov_q && out_ready_in) begin
      ov_d = 1'b0;
    end
    // A new result while the old one leaves keeps valid high, no gap
    if (emit_fire) begin
      out_d = sat(acc_q);
      ov_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      out_q <= `FDF_SAMPLE_RST;
      ov_q <= 1'b0;
    end else begin
      out_q <= out_d;
      ov_q <= ov_d;
    end
  end

  // ***************************************************************
  // Memories
  // ***************************************************************
  // The clear walk and sample writes share one port and never collide
  always_comb begin
    line_we = clr_q || fifo_take;
    line_wdata = fifo_data;
    if (clr_q) begin
      line_wdata = `FDF_SAMPLE_RST;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (line_we) begin
      line_q[wr_q] <= line_wdata;
    end
  end

  // Software loads h(k) at index N-1-k; low-pass per system design
  // Taps are not reset, so all N must be loaded before the first sample
  always_ff @(posedge mclk_in) begin
    if (coef_wr_in.we) begin
      coef_q[coef_wr_in.idx] <= coef_wr_in.value;
    end
  end
endmodule
`default_nettype wire

// ==== include/fdf_consts.svh ====
`ifndef FDF_CONSTS_SVH
`define FDF_CONSTS_SVH
// Data widths
`define FDF_DATA_W 16
`define FDF_COEF_W 16
`define FDF_ACC_W 40
// Number of taps
`define FDF_TAPS 300
// Tap index width
`define FDF_TAP_IW 9
// Decimation factor
`define FDF_DECIM 4
`define FDF_CNT_W 3
// FIFO depth and address width; pointers are one bit wider
`define FDF_FIFO_DEPTH 32
`define FDF_FIFO_AW 5
// Reset values
`define FDF_ACC_RST 40'h0
`define FDF_SAMPLE_RST 16'h0
`endif

// ==== include/fdf_pkg.sv ====
`include "fdf_consts.svh"
`default_nettype none
package fdf_pkg;
  typedef logic signed [`FDF_DATA_W-1:0] fdf_sample_t;
  typedef logic signed [`FDF_COEF_W-1:0] fdf_coef_t;
  typedef logic signed [`FDF_ACC_W-1:0] fdf_acc_t;
  typedef logic [`FDF_TAP_IW-1:0] fdf_tap_idx_t;
  // Coefficient load port
  typedef struct packed {
    logic we;
    fdf_tap_idx_t idx;
    fdf_coef_t value;
  } fdf_coef_wr_t;
  typedef enum logic [1:0] {
    FDF_IDLE,
    FDF_MAC,
    FDF_EMIT
  } fdf_state_t;
endpackage
`default_nettype wire

// ==== tb/fdf_fir_decim_sva.sv ====
`include "fdf_consts.svh"
`default_nettype none
module fdf_fir_decim_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  input wire logic in_ready_out,
  input wire fdf_pkg::fdf_sample_t out_data_out,
  input wire logic out_valid_out,
  input wire logic out_ready_in,
  input wire logic busy_out
);
  int n_in_q;
  int n_in_d;
  int n_out_q;
  int n_out_d;
  always_comb begin
    n_in_d = n_in_q + int'(in_valid_in && in_ready_out);
    n_out_d = n_out_q + int'(out_valid_out && out_ready_in);
  end
  always_ff @(posedge mclk_in) begin
    n_in_q <= rst_n_in ? n_in_d : 0;
    n_out_q <= rst_n_in ? n_out_d : 0;
  end
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_out_held: assert property (
    out_valid_out && !out_ready_in |=> out_valid_out)
    else $error("output dropped before taken");
  a_data_kept: assert property (
    out_valid_out && !out_ready_in |=> $stable(out_data_out))
    else $error("output changed while waiting");
  a_rst_state: assert property (
    $rose(rst_n_in) |-> !out_valid_out && out_data_out == 16'h0)
    else $error("output not cleared by reset");
  a_clear_busy: assert property (
    $rose(rst_n_in) |-> busy_out [*8])
    else $error("no delay line clear after reset");
  a_quota_met: assert property (
    out_valid_out |-> n_in_q >= `FDF_DECIM * (n_out_q + 1))
    else $error("output before its group of inputs");
  // Loose bound: FIFO plus one group in the core and one waiting
  a_quota_upper: assert property (
    out_valid_out |-> n_in_q <= `FDF_DECIM * (n_out_q + 1) + 48)
    else $error("inputs consumed without outputs");
  a_pass_busy: assert property (
    $rose(out_valid_out) |-> $past(busy_out) && $past(busy_out, 8))
    else $error("output without a pass");
  a_full_busy: assert property (
    !in_ready_out |-> busy_out || out_valid_out)
    else $error("input refused while idle");
endmodule
bind fdf_fir_decim fdf_fir_decim_chk i_chk (
  .mclk_in, .rst_n_in, .in_valid_in, .in_ready_out,
  .out_data_out, .out_valid_out, .out_ready_in, .busy_out
);
`default_nettype wire

// ==== tb/fdf_src.sv ====
`default_nettype none
module fdf_src (
  input wire logic mclk_in,
  input wire logic ready_in,
  output fdf_pkg::fdf_sample_t data_out,
  output logic valid_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    data_out = 16'h0;
    valid_out = 1'b0;
  end
  // Called just after an edge; holds until taken
  task automatic push(input fdf_pkg::fdf_sample_t s);
    data_out <= s;
    valid_out <= 1'b1;
    @(posedge mclk_in);
    while (ready_in !== 1'b1) @(posedge mclk_in);
  endtask
  // Released data is inverted so a stale word never looks right
  task automatic idle();
    valid_out <= 1'b0;
    data_out <= ~data_out;
  endtask
endmodule
`default_nettype wire

// ==== tb/fdf_fir_decim_tb.sv ====
`include "fdf_consts.svh"
`default_nettype none
module fdf_fir_decim_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in;
  logic rst_n_in;
  fdf_pkg::fdf_coef_wr_t coef_wr_in;
  fdf_pkg::fdf_sample_t in_data_in;
  logic in_valid_in;
  logic in_ready_out;
  fdf_pkg::fdf_sample_t out_data_out;
  logic out_valid_out;
  logic out_ready_in;
  logic busy_out;
  int seed = 37942;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_got = 0;
  longint h[`FDF_TAPS];
  fdf_pkg::fdf_sample_t xs[$];
  fdf_fir_decim i_dut (.mclk_in, .rst_n_in, .coef_wr_in, .in_data_in,
    .in_valid_in, .in_ready_out, .out_data_out, .out_valid_out,
    .out_ready_in, .busy_out);
  fdf_src i_src (.mclk_in, .ready_in(in_ready_out),
    .data_out(in_data_in), .valid_out(in_valid_in));
  function automatic fdf_pkg::fdf_sample_t exp_out(input int m);
    longint acc;
    int j;
    acc = 0;
    for (int k = 0; k < `FDF_TAPS; k++) begin
      j = `FDF_DECIM * m + `FDF_DECIM - 1 - k;
      if (j >= 0) acc += h[k] * longint'(xs[j]);
    end
    if (acc > 32767) acc = 32767;
    if (acc < -32768) acc = -32768;
    return 16'(acc);
  endfunction
  task automatic chk_samp(input fdf_pkg::fdf_sample_t got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t sample %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    out_ready_in <= ($random(seed) % 4) != 0;
    if (rst_n_in && out_valid_out && out_ready_in) begin
      chk_samp(out_data_out, exp_out(n_got));
      n_got++;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    coef_wr_in = '0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk_bit(out_valid_out, 1'b0);
    chk_bit(in_ready_out, 1'b1);
    chk_bit(busy_out, 1'b1);
    chk_samp(out_data_out, 16'h0);
    // Non-negative taps give a smoothing, low-pass response
    for (int k = 0; k < `FDF_TAPS; k++) begin
      h[k] = longint'({$random(seed)} % 2);
      coef_wr_in <= {1'b1, 9'(`FDF_TAPS - 1 - k), 16'(h[k])};
      @(posedge mclk_in);
    end
    coef_wr_in <= '0;
    // Back to back: the FIFO fills and refuses during passes
    for (int i = 0; i < 96; i++) begin
      xs.push_back(i < 64 ? 16'($random(seed) % 128) :
        i < 80 ? 16'h7fff : 16'h8000);
      i_src.push(xs[i]);
    end
    i_src.idle();
    for (int i = 0; i < 15000 && n_got < 24; i++) @(posedge mclk_in);
    // More than a pass of quiet shows that no extra output follows
    repeat (400) @(posedge mclk_in);
    chk_bit(n_got == 24, 1'b1);
    chk_bit(out_valid_out, 1'b0);
    chk_bit(busy_out, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
